/* verilog/query_check_regs.svh */
// Register offsets, field positions and codes of the translation query check block.
// Assumes an APB slave with 32-bit data; each register takes one aligned word.
`ifndef QUERY_CHECK_REGS_SVH
`define QUERY_CHECK_REGS_SVH

// ============================================================
// Register byte offsets
`define REG_ADDR_LO 12'h000
`define REG_ADDR_HI 12'h004
`define REG_CTRL 12'h008
`define REG_STREAM 12'h00c
`define REG_CONFIG 12'h010
`define REG_RESULT_LO 12'h014
`define REG_RESULT_HI 12'h018
`define REG_STATUS 12'h01c

// ============================================================
// Field positions in the low address word
`define ADDR_TYPE_LSB 0
`define ADDR_RNW_BIT 2
`define ADDR_IND_BIT 3
`define ADDR_PNU_BIT 4
`define ADDR_PAGE_LSB 12

// Control word
`define CTRL_RUN_BIT 0

// Stream word
`define STREAM_SUBSTREAM_ID_VALID_BIT 0
`define STREAM_SECURE_BIT 1

// Configuration word
`define CFG_ENTRY_VALID_BIT 0
`define CFG_CONFIG_LSB 1
`define CFG_DSS_LSB 4
`define CFG_S1_IMPL_BIT 6
`define CFG_S2_IMPL_BIT 7
`define CFG_VM_IF_BIT 8
`define CFG_SECURE_IF_BIT 9

// Result low word
`define RES_FAULT_BIT 0
`define RES_CODE_LSB 1
`define RES_SIZE_LSB 6

// ============================================================
// Codes
`define TYPE_RESERVED 2'h0
`define TYPE_STAGE1 2'h1
`define TYPE_STAGE2 2'h2
`define TYPE_NESTED 2'h3
`define DSS_BYPASS 2'h1
`define CFG_S2_ONLY 3'h6
`define CFG_S1_ONLY 3'h5
`define CFG_BOTH 3'h7
`define CFG_BYPASS_ALL 3'h4
`define CODE_NONE 7'h00
`define CODE_BAD_ENTRY 7'h04
`define CODE_INV_REQUEST 7'h20
`define CODE_INVALID_STAGE_ERROR 7'h21
`define CODE_TRANSLATION 7'h10
`define SIZE_MIN_GRANULE 6'h0c
`define WALK_CYCLES 4'h4
`define ZERO_WORD 32'h0000_0000

`endif

/* verilog/query_check_pkg.sv */
// Types of the translation query check block.
// Assumes the constants header is compiled alongside.
package query_check_pkg;

  // ============================================================
  // States
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_check = 3'b001,
    st_walk = 3'b010,
    st_done = 3'b011
  } state_type;

  // ============================================================
  // Query inputs, written over the bus while no query runs
  typedef struct packed {
    logic [63:0] address;
    logic [31:0] ctrl;
    logic [31:0] stream;
    logic [31:0] config_word;
  } query_regs_type;

  // Result register contents
  typedef struct packed {
    logic [63:0] result;
    logic busy;
  } result_type;

endpackage

/* verilog/translation_query_check.sv */
// Validates a translation query, selects one error code or runs the lookup.
// Assumes an APB master on the same clock; the table walk itself is modelled as a fixed delay.
`timescale 1ns/10ps
`include "query_check_regs.svh"

module translation_query_check #(
  parameter int walk_cycles = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Lookup dispatch
  output logic walk_start,
  output logic [1:0] walk_scope,
  output logic walk_skip_stage1,
  output logic [2:0] walk_attrs
);

  // ============================================================
  // Parameter check
  if (walk_cycles < 1 || walk_cycles > 15) begin : g_walk_cycles_check
    $error("walk_cycles must lie between 1 and 15.");
  end

  // ============================================================
  // State
  typedef struct packed {
    query_check_pkg::state_type state;
    query_check_pkg::query_regs_type regs;
    query_check_pkg::result_type res;
    logic [3:0] count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic walk_start;
    logic [1:0] walk_scope;
    logic walk_skip_stage1;
    logic [2:0] walk_attrs;
  } state_all_type;

  state_all_type s_q;
  state_all_type s_d;

  // ============================================================
  // Decoded query fields
  logic [1:0] qtype;
  logic [2:0] cfg;
  logic [1:0] dss;
  logic s1_impl;
  logic s2_impl;
  logic vm_if;
  logic sec_if;
  logic substream_id_valid;
  logic sec_sel;
  logic entry_valid;
  logic scope_stage1;
  logic scope_stage2;
  logic scope_nested;
  logic scope_wants_s1;
  logic s1_cfg;
  logic s2_cfg;
  logic bypass;

  // ============================================================
  // Error terms, highest priority first
  logic invalid_request_error_reserved;
  logic invalid_request_error_stage1;
  logic invalid_request_error_stage2;
  logic invalid_request_error_nested;
  logic invalid_stage_error_secure;
  logic entry_invalid;
  logic config_pattern;
  logic invalid_stage_error_stage1;
  logic invalid_stage_error_stage2;
  logic invalid_stage_error_nested;
  logic [6:0] code;

  // ============================================================
  // Bus decode
  logic apb_access;
  logic apb_write;
  logic apb_read;
  logic sel_addr_lo;
  logic sel_addr_hi;
  logic sel_ctrl;
  logic sel_stream;
  logic sel_config;
  logic sel_result_lo;
  logic sel_result_hi;
  logic sel_status;
  logic sel_mapped;
  logic [31:0] read_word;

  // ============================================================
  // Write enables
  logic query_open;
  logic wr_addr_lo;
  logic wr_addr_hi;
  logic wr_run;
  logic wr_stream;
  logic wr_config;

  // ============================================================
  // Result words
  logic walk_last;
  logic [5:0] result_size;
  logic [63:0] fault_result;
  logic [63:0] walk_result;

  // ============================================================
  // Query field extraction
  always_comb begin
    qtype = s_q.regs.address[`ADDR_TYPE_LSB +: 2];
    cfg = s_q.regs.config_word[`CFG_CONFIG_LSB +: 3];
    dss = s_q.regs.config_word[`CFG_DSS_LSB +: 2];
    s1_impl = s_q.regs.config_word[`CFG_S1_IMPL_BIT];
    s2_impl = s_q.regs.config_word[`CFG_S2_IMPL_BIT];
    vm_if = s_q.regs.config_word[`CFG_VM_IF_BIT];
    sec_if = s_q.regs.config_word[`CFG_SECURE_IF_BIT];
    entry_valid = s_q.regs.config_word[`CFG_ENTRY_VALID_BIT];
    substream_id_valid = s_q.regs.stream[`STREAM_SUBSTREAM_ID_VALID_BIT];
    sec_sel = s_q.regs.stream[`STREAM_SECURE_BIT];
    scope_stage1 = (qtype == `TYPE_STAGE1);
    scope_stage2 = (qtype == `TYPE_STAGE2);
    scope_nested = (qtype == `TYPE_NESTED);
    scope_wants_s1 = scope_stage1 || scope_nested;
    s1_cfg = (cfg == `CFG_S1_ONLY) || (cfg == `CFG_BOTH);
    s2_cfg = (cfg == `CFG_S2_ONLY) || (cfg == `CFG_BOTH);
    bypass = !substream_id_valid && (dss == `DSS_BYPASS);
  end

  // ============================================================
  // Error conditions
  always_comb begin
    invalid_request_error_reserved = (qtype == `TYPE_RESERVED);
    invalid_request_error_stage1 = scope_stage1 && !s1_impl;
    invalid_request_error_stage2 = scope_stage2 && (vm_if || !s2_impl || substream_id_valid);
    invalid_request_error_nested = scope_nested && (vm_if || !s1_impl || !s2_impl);
    invalid_stage_error_secure = sec_if && sec_sel && (scope_stage2 || scope_nested);
    entry_invalid = !entry_valid;
    config_pattern = !cfg[2] || (cfg == `CFG_BYPASS_ALL);
    invalid_stage_error_stage1 = scope_stage1 && !s1_cfg;
    invalid_stage_error_stage2 = scope_stage2 && !s2_cfg;
    invalid_stage_error_nested = scope_nested && !(s1_cfg && s2_cfg);
  end

  // ============================================================
  // Error selection
  always_comb begin
    code = `CODE_NONE;
    if (invalid_request_error_reserved) begin
      code = `CODE_INV_REQUEST;
    end else if (invalid_request_error_stage1) begin
      code = `CODE_INV_REQUEST;
    end else if (invalid_request_error_stage2) begin
      code = `CODE_INV_REQUEST;
    end else if (invalid_request_error_nested) begin
      code = `CODE_INV_REQUEST;
    end else if (invalid_stage_error_secure) begin
      code = `CODE_INVALID_STAGE_ERROR;
    end else if (entry_invalid) begin
      code = `CODE_BAD_ENTRY;
    end else if (config_pattern) begin
      code = vm_if ? `CODE_BAD_ENTRY : `CODE_INVALID_STAGE_ERROR;
    end else if (invalid_stage_error_stage1) begin
      code = `CODE_INVALID_STAGE_ERROR;
    end else if (invalid_stage_error_stage2) begin
      code = `CODE_INVALID_STAGE_ERROR;
    end else if (invalid_stage_error_nested) begin
      code = `CODE_INVALID_STAGE_ERROR;
    end
  end

  // ============================================================
  // Register select
  always_comb begin
    apb_access = psel && penable && !s_q.pready;
    apb_write = apb_access && pwrite;
    apb_read = apb_access && !pwrite;
    sel_addr_lo = 1'b0;
    sel_addr_hi = 1'b0;
    sel_ctrl = 1'b0;
    sel_stream = 1'b0;
    sel_config = 1'b0;
    sel_result_lo = 1'b0;
    sel_result_hi = 1'b0;
    sel_status = 1'b0;
    if (paddr == `REG_ADDR_LO) begin
      sel_addr_lo = 1'b1;
    end else if (paddr == `REG_ADDR_HI) begin
      sel_addr_hi = 1'b1;
    end else if (paddr == `REG_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (paddr == `REG_STREAM) begin
      sel_stream = 1'b1;
    end else if (paddr == `REG_CONFIG) begin
      sel_config = 1'b1;
    end else if (paddr == `REG_RESULT_LO) begin
      sel_result_lo = 1'b1;
    end else if (paddr == `REG_RESULT_HI) begin
      sel_result_hi = 1'b1;
    end else if (paddr == `REG_STATUS) begin
      sel_status = 1'b1;
    end
    sel_mapped = sel_addr_lo || sel_addr_hi || sel_ctrl || sel_stream
      || sel_config || sel_result_lo || sel_result_hi || sel_status;
  end

  // ============================================================
  // Read data
  always_comb begin
    read_word = `ZERO_WORD;
    if (sel_addr_lo) begin
      read_word = s_q.regs.address[31:0];
    end else if (sel_addr_hi) begin
      read_word = s_q.regs.address[63:32];
    end else if (sel_ctrl) begin
      read_word = {31'h0000_0000, s_q.res.busy};
    end else if (sel_stream) begin
      read_word = s_q.regs.stream;
    end else if (sel_config) begin
      read_word = s_q.regs.config_word;
    end else if (sel_result_lo) begin
      read_word = s_q.res.result[31:0];
    end else if (sel_result_hi) begin
      read_word = s_q.res.result[63:32];
    end else if (sel_status) begin
      read_word = {28'h000_0000, 1'b0, s_q.state};
    end
  end

  // ============================================================
  // Write enables
  always_comb begin
    query_open = !s_q.res.busy;
    wr_addr_lo = apb_write && sel_addr_lo && query_open;
    wr_addr_hi = apb_write && sel_addr_hi && query_open;
    wr_run = apb_write && sel_ctrl && query_open && pwdata[`CTRL_RUN_BIT];
    wr_stream = apb_write && sel_stream && query_open;
    wr_config = apb_write && sel_config && query_open;
  end

  // ============================================================
  // Result words
  always_comb begin
    walk_last = (s_q.count <= 4'h1);
    result_size = `SIZE_MIN_GRANULE;
    fault_result = {56'h00_0000_0000_0000, code, 1'b1};
    walk_result = {s_q.regs.address[63:`ADDR_PAGE_LSB], result_size, 5'h00, 1'b0};
  end

  // ============================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pready = apb_access;
    s_d.pslverr = apb_access && !sel_mapped;
    s_d.walk_start = 1'b0;
    // Writes to the query group are ignored while a query runs.
    if (wr_addr_lo) begin
      s_d.regs.address[31:0] = pwdata;
    end
    if (wr_addr_hi) begin
      s_d.regs.address[63:32] = pwdata;
    end
    if (wr_stream) begin
      s_d.regs.stream = pwdata;
    end
    if (wr_config) begin
      s_d.regs.config_word = pwdata;
    end
    if (wr_run) begin
      s_d.res.busy = 1'b1;
      s_d.state = query_check_pkg::st_check;
    end
    if (apb_read) begin
      s_d.prdata = read_word;
    end
    case (s_q.state)
      query_check_pkg::st_idle: begin
      end
      query_check_pkg::st_check: begin
        if (code != `CODE_NONE) begin
          s_d.res.result = fault_result;
          s_d.state = query_check_pkg::st_done;
        end else begin
          s_d.walk_start = 1'b1;
          s_d.walk_scope = qtype;
          s_d.walk_skip_stage1 = bypass && scope_wants_s1;
          s_d.walk_attrs = s_q.regs.address[`ADDR_RNW_BIT +: 3];
          s_d.count = 4'(walk_cycles);
          s_d.state = query_check_pkg::st_walk;
        end
      end
      query_check_pkg::st_walk: begin
        if (!walk_last) begin
          s_d.count = s_q.count - 4'h1;
        end else begin
          s_d.res.result = walk_result;
          s_d.state = query_check_pkg::st_done;
        end
      end
      query_check_pkg::st_done: begin
        s_d.res.busy = 1'b0;
        s_d.state = query_check_pkg::st_idle;
      end
      default: begin
        s_d.state = query_check_pkg::st_idle;
      end
    endcase
  end

  // ============================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Outputs
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign walk_start = s_q.walk_start;
  assign walk_scope = s_q.walk_scope;
  assign walk_skip_stage1 = s_q.walk_skip_stage1;
  assign walk_attrs = s_q.walk_attrs;

endmodule // translation_query_check

/* test/translation_query_check_sva.sv */
// Checker for the translation query check block.
// Assumes it is bound to translation_query_check.
`timescale 1ns/10ps
module translation_query_check_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Dispatch
  input wire logic walk_start,
  input wire logic [1:0] walk_scope,
  input wire logic walk_skip_stage1
);
  // ====
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_walk; walk_start |=> !walk_start; endproperty
  a_walk: assert property (p_walk) else $error("walk held");
  property p_scope; walk_start |-> walk_scope != 2'h0; endproperty
  a_scope: assert property (p_scope) else $error("reserved dispatched");
  property p_skip; walk_start && walk_skip_stage1 |-> walk_scope[0]; endproperty
  a_skip: assert property (p_skip) else $error("bad skip");
  property p_hold; $changed(walk_scope) |-> walk_start; endproperty
  a_hold: assert property (p_hold) else $error("scope moved");
  property p_quiet; disable iff (1'h0) reset |=> !pready && !walk_start; endproperty
  a_quiet: assert property (p_quiet) else $error("active in reset");
  c_skip: cover property (walk_start && walk_skip_stage1);
  c_nest: cover property (walk_start && walk_scope == 2'h3);
  c_err: cover property (pslverr);
endmodule // translation_query_check_sva

bind translation_query_check translation_query_check_sva i_sva (.mclk, .reset, .psel, .penable, .pready,
  .pslverr, .walk_start, .walk_scope, .walk_skip_stage1);

/* test/translation_query_check_bench.sv */
// Self-checking bench for the translation query check block.
// Assumes the header, package, design and checker are compiled first.
`timescale 1ns/10ps
module translation_query_check_bench;
  // ====
  // Signals
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic walk_start;
  logic [1:0] walk_scope;
  logic walk_skip_stage1;
  logic [2:0] walk_attrs;
  logic [31:0] rd;
  logic er;
  logic [5:0] wk;
  int walks = 0;
  int mismatches = 0;
  int n_checks = 0;

  always #12.5 mclk = ~mclk;

  translation_query_check i_translation_query_check (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .walk_start, .walk_scope, .walk_skip_stage1, .walk_attrs);

  always @(posedge mclk) begin
    if (walk_start === 1'h1) begin
      walks <= walks + 1;
      wk <= {walk_scope, walk_skip_stage1, walk_attrs};
    end
  end

  // ====
  // Tasks
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      mismatches++;
      complete_run;
    end
  endtask

  // Runs one query and judges either the error code or the dispatched walk.
  task automatic q(input logic [1:0] t, input logic [9:0] c, input logic [1:0] s, input logic [6:0] code,
    input logic sk);
    int w0;
    int n;
    apb(1'h1, 12'h000, {20'h12345, 7'h00, t[0], ~t[0], t[0], t});
    apb(1'h1, 12'h004, 32'h0000_00ab);
    apb(1'h1, 12'h00c, {30'h0, s});
    apb(1'h1, 12'h010, {22'h0, c});
    w0 = walks;
    apb(1'h1, 12'h008, 32'h1);
    n = 0;
    do begin
      apb(1'h0, 12'h008, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 40);
    if (n >= 40) begin
      mismatches++;
      complete_run;
    end
    apb(1'h0, 12'h014, 32'h0);
    if (code == 7'h00) begin
      chk("fault", 32'h0, {31'h0, rd[0]});
      chk("walks", w0 + 1, walks);
      chk("walk", {26'h0, t, sk, t[0], ~t[0], t[0]}, {26'h0, wk});
      chk("low", {20'h12345, 6'h0c, 6'h00}, rd);
      apb(1'h0, 12'h018, 32'h0);
      chk("high", 32'h0000_00ab, rd);
    end else begin
      chk("code", {24'h0, code, 1'h1}, {24'h0, rd[7:0]});
      chk("walks", w0, walks);
    end
  endtask

  // ====
  // Scenarios
  task automatic scen_regs;
    apb(1'h0, 12'h008, 32'h0);
    chk("run", 32'h0, rd);
    apb(1'h0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("rdata", 32'h0, rd);
  endtask

  task automatic scen_stage1;
    q(2'h0, 10'h0cf, 2'h0, 7'h20, 1'h0);
    q(2'h1, 10'h08f, 2'h0, 7'h20, 1'h0);
    q(2'h1, 10'h0cd, 2'h0, 7'h21, 1'h0);
    q(2'h1, 10'h0cb, 2'h0, 7'h00, 1'h0);
    q(2'h1, 10'h0cf, 2'h0, 7'h00, 1'h0);
    q(2'h1, 10'h14b, 2'h0, 7'h00, 1'h0);
  endtask

  task automatic scen_stage2;
    q(2'h2, 10'h1cf, 2'h0, 7'h20, 1'h0);
    q(2'h2, 10'h04f, 2'h0, 7'h20, 1'h0);
    q(2'h2, 10'h0cb, 2'h0, 7'h21, 1'h0);
    q(2'h2, 10'h0cf, 2'h0, 7'h00, 1'h0);
    q(2'h2, 10'h2cf, 2'h2, 7'h21, 1'h0);
    q(2'h2, 10'h0cf, 2'h1, 7'h20, 1'h0);
    q(2'h2, 10'h0df, 2'h0, 7'h00, 1'h0);
  endtask

  task automatic scen_nested;
    q(2'h3, 10'h1cf, 2'h0, 7'h20, 1'h0);
    q(2'h3, 10'h08f, 2'h0, 7'h20, 1'h0);
    q(2'h3, 10'h0cb, 2'h0, 7'h21, 1'h0);
    q(2'h3, 10'h2cf, 2'h2, 7'h21, 1'h0);
    q(2'h3, 10'h0df, 2'h0, 7'h00, 1'h1);
  endtask

  task automatic scen_entry;
    q(2'h1, 10'h0ca, 2'h0, 7'h04, 1'h0);
    q(2'h1, 10'h0c7, 2'h0, 7'h21, 1'h0);
    q(2'h1, 10'h0c9, 2'h0, 7'h21, 1'h0);
    q(2'h1, 10'h1c7, 2'h0, 7'h04, 1'h0);
  endtask

  task automatic scen_bypass;
    q(2'h1, 10'h0db, 2'h0, 7'h00, 1'h1);
    q(2'h1, 10'h0dd, 2'h0, 7'h21, 1'h0);
    q(2'h1, 10'h0db, 2'h1, 7'h00, 1'h0);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'h0;
    scen_regs;
    scen_stage1;
    scen_stage2;
    scen_nested;
    scen_entry;
    scen_bypass;
    complete_run;
  end
endmodule // translation_query_check_bench
